// ===== bench/srcs_far_end.sv
// Far side model: strap drivers with pull-downs and the pulled-up lock line
`timescale 1ns/100ps
`default_nettype none
module srcs_far_end (
    input wire logic strap_drive,
    input wire logic [2:0] strap_val,
    input wire logic lock_indicator_out,
    input wire logic lock_indicator_oe,
    output logic strap_mode,
    output logic strap_fsel_hi,
    output logic strap_fsel_lo,
    output logic lock_line
);
    // Undriven straps settle at the pull-down level, never at a stale value
    assign {strap_mode, strap_fsel_hi, strap_fsel_lo} = strap_drive ? strap_val : 3'h0;
    // Open-drain wire: the pull-up wins unless the device sinks it
    assign lock_line = lock_indicator_oe ? lock_indicator_out : 1'b1;
endmodule
`default_nettype wire

// ===== bench/srcs_monitor.sv
// Port-level assertion checker for the sequencer, bound into its top
`timescale 1ns/100ps
`default_nettype none
module srcs_monitor #(
    parameter int CAL_CYCLES = 64
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic ext_reset_low_pin,
    input wire logic power_on_reset,
    input wire logic output_enable_low_pin,
    input wire logic sw_out_disable,
    input wire logic sw_recal,
    input wire logic sw_tune_valid,
    input wire logic [9:0] sw_tune_ppm,
    input wire logic lock_indicator_oe,
    input wire logic [11:0] vco_target_mhz,
    input wire logic vco_cal_active,
    input wire logic vco_fine_active,
    input wire logic tune_out_of_range,
    input wire logic bus_if_reset,
    input wire logic [2:0] strap_latched,
    input wire logic high_speed_clock_out,
    input wire logic low_speed_clock_out
);
    logic rst_any;
    logic [7:0] cal_cnt;
    assign rst_any = reset || power_on_reset || !ext_reset_low_pin;
    // Length of the running calibration; restarts whenever it is left
    always_ff @(posedge clk_sys)
    begin
        cal_cnt <= (rst_any || !vco_cal_active) ? 8'h00 : cal_cnt + 8'h01;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst_any);
    sequence cal_ends;
        vco_cal_active ##1 !vco_cal_active;
    endsequence
    sequence lock_gained;
        vco_fine_active ##1 !vco_fine_active && !vco_cal_active;
    endsequence
    rst_hold_a:
    assert property (disable iff (1'b0) rst_any |=> lock_indicator_oe && bus_if_reset &&
        !high_speed_clock_out && !low_speed_clock_out && vco_target_mhz == 12'h9C4)
        else $error("reset state not held");
    cal_length_a:
    assert property ($fell(vco_cal_active) |-> cal_cnt == CAL_CYCLES) else $error("cal length");
    cal_to_fine_a:
    assert property (cal_ends |-> vco_fine_active) else $error("no fine-lock after cal");
    lock_release_a:
    assert property (lock_gained |-> ##[0:1] !lock_indicator_oe) else $error("lock not released");
    ld_low_a:
    assert property (vco_cal_active || vco_fine_active |-> lock_indicator_oe) else $error("ld off");
    recal_start_a:
    assert property (sw_recal && !lock_indicator_oe |=> vco_cal_active) else $error("no recal");
    tune_window_a:
    assert property (sw_tune_valid && !lock_indicator_oe |=>
        tune_out_of_range == ($past(sw_tune_ppm) > 10'h1F4))
        else $error("tune flag wrong");
    out_gate_a:
    assert property ((output_enable_low_pin || sw_out_disable) [*3] |->
        !high_speed_clock_out && !low_speed_clock_out) else $error("outputs not gated");
    straps_hold_a:
    assert property (!rst_any [*2] |-> $stable(strap_latched)) else $error("straps moved");
endmodule
bind srcs_top srcs_monitor #(.CAL_CYCLES(CAL_CYCLES)) srcs_monitor_i (.clk_sys(clk_sys),
    .reset(reset), .ext_reset_low_pin(ext_reset_low_pin), .power_on_reset(power_on_reset),
    .output_enable_low_pin(output_enable_low_pin), .sw_out_disable(sw_out_disable),
    .sw_recal(sw_recal), .sw_tune_valid(sw_tune_valid), .sw_tune_ppm(sw_tune_ppm),
    .lock_indicator_oe(lock_indicator_oe), .vco_target_mhz(vco_target_mhz),
    .vco_cal_active(vco_cal_active), .vco_fine_active(vco_fine_active),
    .tune_out_of_range(tune_out_of_range), .bus_if_reset(bus_if_reset),
    .strap_latched(strap_latched), .high_speed_clock_out(high_speed_clock_out),
    .low_speed_clock_out(low_speed_clock_out));
`default_nettype wire

// ===== bench/srcs_top_tb_top.sv
// Self-checking bench: strap table, lock timing, output gating, tune, recal
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin fail_count++; $display("BAD %0t %s", $time, m); end end
module srcs_top_tb_top;
    localparam int CAL = 4;
    localparam int LCK = 4;
    logic clk_sys = 1'b0, reset = 1'b1, ext_reset_low_pin = 1'b1, power_on_reset = 1'b0;
    logic drive = 1'b0, oe_low = 1'b0, sw_dis = 1'b0, sw_recal = 1'b0, tune_v = 1'b0;
    logic hs_en = 1'b1, ls_en = 1'b1, fb_sel = 1'b0, cfg_write = 1'b0;
    logic [2:0] sval = 3'h0, last = 3'h0;
    logic [9:0] tune_ppm = 10'h000;
    logic [7:0] cfg_div = 8'h19;
    logic s_hi, s_lo, s_mode, ld_out, ld_oe, lock_line, by2, cal_on, oor, hs, ls, fb;
    logic [15:0] fin;
    logic [11:0] vco;
    logic [19:0] hs_def, ls_def;
    logic [2:0] latched;
    int fail_count = 0, checked = 0, hs_n = 0, ls_n = 0, fb_n = 0;
    // Rows: {drive, mode, fsel_hi, fsel_lo}, reset source, expected input kHz
    logic [3:0] r_strap [6] = '{4'hB, 4'hE, 4'hD, 4'h8, 4'h7, 4'hF};
    int r_src [6] = '{0, 1, 2, 0, 2, 2};
    logic [15:0] r_fin [6] = '{srcs_pkg::FIN_KHZ_25M, srcs_pkg::FIN_KHZ_12M8,
        srcs_pkg::FIN_KHZ_10M, srcs_pkg::FIN_KHZ_20M, srcs_pkg::FIN_KHZ_20M, srcs_pkg::FIN_KHZ_25M};
    // Gate rows: {oe pin, sw off, hs on, ls on, fb sel, hs runs, ls runs, fb silent}
    logic [7:0] g_row [5] = '{8'h36, 8'hB0, 8'h70, 8'h13, 8'h2D};

    always #12.5 clk_sys = ~clk_sys;
    // Rising-edge counters for the three clock outputs
    always @(posedge hs) hs_n++;
    always @(posedge ls) ls_n++;
    always @(posedge fb) fb_n++;

    srcs_top #(.CAL_CYCLES(CAL), .LOCK_CYCLES(LCK)) srcs_top_i (.clk_sys(clk_sys),
        .reset(reset), .ext_reset_low_pin(ext_reset_low_pin), .power_on_reset(power_on_reset),
        .strap_fsel_hi(s_hi), .strap_fsel_lo(s_lo), .strap_mode(s_mode),
        .output_enable_low_pin(oe_low), .sw_out_disable(sw_dis), .sw_recal(sw_recal),
        .sw_tune_valid(tune_v), .sw_tune_ppm(tune_ppm), .hs_div_enable(hs_en),
        .ls_div_enable(ls_en), .fb_src_sel(fb_sel), .cfg_write(cfg_write),
        .cfg_pre_div(cfg_div), .cfg_hs_div(cfg_div), .cfg_ls_div(cfg_div), .cfg_fb_div(cfg_div),
        .lock_indicator_out(ld_out), .lock_indicator_oe(ld_oe), .ref_div_by2(by2),
        .fin_khz(fin), .vco_target_mhz(vco), .vco_cal_active(cal_on), .vco_fine_active(),
        .tune_out_of_range(oor), .default_hs_khz(hs_def), .default_ls_khz(ls_def),
        .bus_if_reset(), .strap_latched(latched), .high_speed_clock_out(hs),
        .low_speed_clock_out(ls), .feedback_clock_out(fb));
    srcs_far_end srcs_far_end_i (.strap_drive(drive), .strap_val(sval),
        .lock_indicator_out(ld_out), .lock_indicator_oe(ld_oe), .strap_mode(s_mode),
        .strap_fsel_hi(s_hi), .strap_fsel_lo(s_lo), .lock_line(lock_line));

    task automatic stop_test();
        if (fail_count == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Holds one reset source for six cycles, then checks that the lock line is low
    task automatic do_reset(input int src);
        reset = (src == 0);
        power_on_reset = (src == 1);
        ext_reset_low_pin = (src != 2);
        repeat (6) @(negedge clk_sys);
        `CHK(lock_line, 1'b0, "lock line high in reset")
        reset = 1'b0;
        power_on_reset = 1'b0;
        ext_reset_low_pin = 1'b1;
    endtask
    // Bounded wait for the lock line, counting cycles
    task automatic wait_lock(input int exp);
        int n;
        n = 0;
        while (lock_line !== 1'b1 && n < 300)
        begin
            @(negedge clk_sys);
            n++;
        end
        `CHK(n, exp, "lock time")
        if (n >= 300)
            stop_test();
    endtask

    initial
    begin
        for (int i = 0; i < 6; i++)
        begin
            {drive, sval} = r_strap[i];
            // Row 0 goes straight into reset so the start-up reset lasts six cycles
            if (i > 0)
            begin
                repeat (2) @(negedge clk_sys);
                `CHK(latched, last, "strap taken outside reset")
            end
            do_reset(r_src[i]);
            wait_lock(CAL + LCK + 1);
            last = drive ? sval : 3'h0;
            `CHK(latched, last, "strap capture")
            `CHK(fin, r_fin[i], "input freq")
            `CHK(by2, last[1] ~^ last[0], "pre-divider")
            `CHK(hs_def, last[2] ? 20'h2625A : 20'h1E848, "hs default")
            `CHK(ls_def, 20'h061A8, "ls default")
            `CHK(vco, 12'h9C4, "vco target")
        end
        // Short ratios so each output toggles many times per window
        cfg_div = 8'h02;
        cfg_write = 1'b1;
        @(negedge clk_sys);
        cfg_write = 1'b0;
        foreach (g_row[i])
        begin
            {oe_low, sw_dis, hs_en, ls_en, fb_sel} = g_row[i][7:3];
            repeat (4) @(negedge clk_sys);
            {hs_n, ls_n, fb_n} = '0;
            repeat (64) @(negedge clk_sys);
            `CHK(hs_n != 0, g_row[i][2], "hs gating")
            `CHK(ls_n != 0, g_row[i][1], "ls gating")
            `CHK(fb_n == 0, g_row[i][0], "fb source")
        end
        // Tune window edge: 500 is inside, 501 is not, flag lasts one cycle
        {tune_v, tune_ppm} = {1'b1, 10'h1F4};
        @(negedge clk_sys);
        tune_ppm = 10'h1F5;
        `CHK(oor, 1'b0, "500 ppm flagged")
        @(negedge clk_sys);
        tune_v = 1'b0;
        `CHK(oor, 1'b1, "501 ppm missed")
        @(negedge clk_sys);
        `CHK(oor, 1'b0, "flag stuck")
        sw_recal = 1'b1;
        @(negedge clk_sys);
        sw_recal = 1'b0;
        `CHK({cal_on, lock_line}, 2'h2, "recal start")
        wait_lock(CAL + LCK);
        `CHK({latched, fin}, {3'h7, srcs_pkg::FIN_KHZ_25M}, "recal kept setup")
        stop_test();
    end
endmodule
`default_nettype wire

// ===== hdl/srcs_div.sv
// Programmable clock divider with enable; held low while disabled
`timescale 1ns/100ps
`default_nettype none
module srcs_div #(
    parameter int WIDTH = 8
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic enable,
    input wire logic [WIDTH-1:0] ratio,
    output logic clk_out
);

    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic out;
    } srcs_div_t;

    srcs_div_t cur;
    srcs_div_t next_cur;

    // Half-ratio toggling; ratio 0 or 1 is treated as divide by two
    always_comb
    begin
        next_cur = cur;
        if (!enable)
        begin
            next_cur.count = '0;
            next_cur.out = 1'b0;
        end
        else if (cur.count >= ((ratio >> 1) == '0 ? WIDTH'(0) : WIDTH'((ratio >> 1) - 1'b1)))
        begin
            next_cur.count = '0;
            next_cur.out = ~cur.out;
        end
        else
        begin
            next_cur.count = cur.count + 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            cur <= '0;
        else
            cur <= next_cur;
    end

    assign clk_out = cur.out;

endmodule
`default_nettype wire

// ===== hdl/srcs_top.sv
// Reset, strap capture, VCO calibration sequencing and output divider control
// Function
// - 10 or 12.8 MHz input: reference pre-divider bypassed.
// - 20 or 25 MHz input: reference pre-divider divides by two.
// - Straps decode 00=20, 01=10, 10=12.8, 11=25 MHz.
// - Lock runs in two phases: calibration, then fine-lock.
// - In fine-lock, tuning within 500 ppm needs no recalibration.
// - Reset sets VCO target to 2.5 GHz before calibration.
// - Lock indicator driven low during calibration, released on lock.
// - VCO feeds shared prescaler, two output dividers, feedback divider.
// - Each output divider can be switched off independently.
// - Feedback divider fed from first or second output divider.
// - Outputs disabled by high enable pin or by software.
// - Reset from power monitor or external active-low pin.
// - During reset: defaults restored, bus reset, clocks held inactive.
// - After reset, defaults chosen from sampled mode and frequency straps.
// - Calibration starts after reset; on completion lock released, outputs on.
// - Straps captured only during reset; floating straps read zero.
// - Mode strap 0: 125/25 MHz; 1: 156.25/25 MHz defaults.
`timescale 1ns/100ps
`default_nettype none
module srcs_top #(
    parameter int CAL_CYCLES = srcs_pkg::CAL_CYCLES_DEF,
    parameter int LOCK_CYCLES = srcs_pkg::LOCK_CYCLES_DEF
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic ext_reset_low_pin,
    input wire logic power_on_reset,
    input wire logic strap_fsel_hi,
    input wire logic strap_fsel_lo,
    input wire logic strap_mode,
    input wire logic output_enable_low_pin,
    input wire logic sw_out_disable,
    input wire logic sw_recal,
    input wire logic sw_tune_valid,
    input wire logic [9:0] sw_tune_ppm,
    input wire logic hs_div_enable,
    input wire logic ls_div_enable,
    input wire logic fb_src_sel,
    input wire logic cfg_write,
    input wire logic [7:0] cfg_pre_div,
    input wire logic [7:0] cfg_hs_div,
    input wire logic [7:0] cfg_ls_div,
    input wire logic [7:0] cfg_fb_div,
    output logic lock_indicator_out,
    output logic lock_indicator_oe,
    output logic ref_div_by2,
    output logic [15:0] fin_khz,
    output logic [11:0] vco_target_mhz,
    output logic vco_cal_active,
    output logic vco_fine_active,
    output logic tune_out_of_range,
    output logic [19:0] default_hs_khz,
    output logic [19:0] default_ls_khz,
    output logic bus_if_reset,
    output logic [2:0] strap_latched,
    output logic high_speed_clock_out,
    output logic low_speed_clock_out,
    output logic feedback_clock_out
);

    // Reference frequency for a strap code
    function automatic logic [15:0] fsel_khz(input logic [1:0] code);
        logic [15:0] f;
        f = srcs_pkg::FIN_KHZ_20M;
        case (code)
            srcs_pkg::FSEL_10M: f = srcs_pkg::FIN_KHZ_10M;
            srcs_pkg::FSEL_12M8: f = srcs_pkg::FIN_KHZ_12M8;
            srcs_pkg::FSEL_25M: f = srcs_pkg::FIN_KHZ_25M;
            default: f = srcs_pkg::FIN_KHZ_20M;
        endcase
        return f;
    endfunction

    typedef struct packed {
        srcs_pkg::srcs_state_t state;
        logic [15:0] timer;
        logic [2:0] straps;
        logic ref_by2;
        logic [15:0] fin;
        logic [11:0] vco;
        logic [7:0] pre_div;
        logic [7:0] hs_div;
        logic [7:0] ls_div;
        logic [7:0] fb_div;
        logic [19:0] hs_khz;
        logic [19:0] ls_khz;
        logic ld_oe;
        logic out_en;
        logic bus_rst;
        logic tune_oor;
        logic pre_clk;
        logic hs_clk;
        logic ls_clk;
        logic fb_clk;
    } srcs_top_t;

    srcs_top_t cur;
    srcs_top_t next_cur;
    logic dev_reset;
    logic pre_tick;
    logic hs_raw;
    logic ls_raw;
    logic fb_raw;

    // Any of the three reset sources puts the whole device into reset
    assign dev_reset = reset | power_on_reset | ~ext_reset_low_pin;

    // Shared prescaler driven by the VCO stand-in (system clock)
    srcs_div #(.WIDTH(8)) u_pre (
        .clk_sys(clk_sys),
        .reset(dev_reset),
        .enable(~dev_reset),
        .ratio(cur.pre_div),
        .clk_out(pre_tick)
    );

    // Per-output dividers; each may be switched off on its own
    srcs_div #(.WIDTH(8)) u_hs (
        .clk_sys(clk_sys),
        .reset(dev_reset),
        .enable(hs_div_enable & pre_tick),
        .ratio(cur.hs_div),
        .clk_out(hs_raw)
    );

    srcs_div #(.WIDTH(8)) u_ls (
        .clk_sys(clk_sys),
        .reset(dev_reset),
        .enable(ls_div_enable & pre_tick),
        .ratio(cur.ls_div),
        .clk_out(ls_raw)
    );

    // Feedback divider source mux: 0 = first output, 1 = second output
    srcs_div #(.WIDTH(8)) u_fb (
        .clk_sys(clk_sys),
        .reset(dev_reset),
        .enable(fb_src_sel ? ls_raw : hs_raw),
        .ratio(cur.fb_div),
        .clk_out(fb_raw)
    );

    // Sequencer and configuration state; straps sampled only in reset
    always_comb
    begin
        next_cur = cur;
        next_cur.bus_rst = 1'b0;
        next_cur.tune_oor = 1'b0;
        if (dev_reset)
        begin
            next_cur = '0; // All registers back to defaults
            // Pins have pull-downs, so an undriven strap arrives as zero
            next_cur.straps = {strap_mode, strap_fsel_hi, strap_fsel_lo};
            next_cur.state = srcs_pkg::SRCS_RESET;
            next_cur.timer = '0;
            next_cur.bus_rst = 1'b1;
            next_cur.out_en = 1'b0;
            next_cur.ld_oe = 1'b1;
            next_cur.vco = srcs_pkg::VCO_RESET_MHZ;
            next_cur.hs_clk = 1'b0;
            next_cur.ls_clk = 1'b0;
            next_cur.fb_clk = 1'b0;
        end
        else
        begin
            case (cur.state)
                srcs_pkg::SRCS_RESET:
                begin
                    // Defaults follow the latched straps, not the live pins
                    next_cur.fin = fsel_khz(cur.straps[1:0]);
                    if (cur.straps[1:0] == srcs_pkg::FSEL_10M ||
                        cur.straps[1:0] == srcs_pkg::FSEL_12M8)
                        next_cur.ref_by2 = srcs_pkg::REF_DIV_BYPASS;
                    else
                        next_cur.ref_by2 = srcs_pkg::REF_DIV_BY2;
                    next_cur.pre_div = srcs_pkg::PRE_DIV_DEF;
                    next_cur.ls_div = srcs_pkg::LS_DIV_DEF;
                    next_cur.fb_div = srcs_pkg::FB_DIV_DEF;
                    next_cur.ls_khz = srcs_pkg::OUT_LS_KHZ_DEF;
                    if (cur.straps[2])
                    begin
                        next_cur.hs_div = srcs_pkg::HS_DIV_MODE1;
                        next_cur.hs_khz = srcs_pkg::OUT_HS_KHZ_MODE1;
                    end
                    else
                    begin
                        next_cur.hs_div = srcs_pkg::HS_DIV_MODE0;
                        next_cur.hs_khz = srcs_pkg::OUT_HS_KHZ_MODE0;
                    end
                    next_cur.state = srcs_pkg::SRCS_CAL;
                    next_cur.timer = '0;
                    next_cur.ld_oe = 1'b1;
                end
                srcs_pkg::SRCS_CAL:
                begin
                    // Phase one: pick the VCO operating point
                    next_cur.ld_oe = 1'b1;
                    if (cur.timer >= 16'(CAL_CYCLES - 1))
                    begin
                        next_cur.state = srcs_pkg::SRCS_FINE;
                        next_cur.timer = '0;
                    end
                    else
                        next_cur.timer = cur.timer + 16'h0001;
                end
                srcs_pkg::SRCS_FINE:
                begin
                    // Phase two: tune until phase-locked
                    next_cur.ld_oe = 1'b1;
                    if (cur.timer >= 16'(LOCK_CYCLES - 1))
                    begin
                        next_cur.state = srcs_pkg::SRCS_LOCKED;
                        next_cur.ld_oe = 1'b0;
                        next_cur.out_en = 1'b1;
                        next_cur.timer = '0;
                    end
                    else
                        next_cur.timer = cur.timer + 16'h0001;
                end
                srcs_pkg::SRCS_LOCKED:
                begin
                    next_cur.ld_oe = 1'b0;
                    // Small tuning stays locked; a large move needs recalibration
                    if (sw_tune_valid && sw_tune_ppm > srcs_pkg::TUNE_WINDOW_PPM)
                        next_cur.tune_oor = 1'b1;
                    if (cfg_write)
                    begin
                        next_cur.pre_div = cfg_pre_div;
                        next_cur.hs_div = cfg_hs_div;
                        next_cur.ls_div = cfg_ls_div;
                        next_cur.fb_div = cfg_fb_div;
                    end
                end
                default:
                    next_cur.state = srcs_pkg::SRCS_RESET;
            endcase
            // Recalibration keeps dividers, only restarts the lock sequence
            if (sw_recal && cur.state != srcs_pkg::SRCS_RESET)
            begin
                next_cur.state = srcs_pkg::SRCS_CAL;
                next_cur.timer = '0;
                next_cur.ld_oe = 1'b1;
            end
            // Output gating registered so the pins come straight from flops
            next_cur.hs_clk = hs_raw & cur.out_en & ~output_enable_low_pin
                & ~sw_out_disable;
            next_cur.ls_clk = ls_raw & cur.out_en & ~output_enable_low_pin
                & ~sw_out_disable;
            next_cur.fb_clk = fb_raw; // Source already picked at the divider input
        end
    end

    // Reset is folded into next_cur, so every reset source also samples the straps
    always_ff @(posedge clk_sys)
    begin
        cur <= next_cur;
    end

    // Outputs come from state flops, except lock_indicator_out, which is tied low
    assign lock_indicator_out = 1'b0;
    assign lock_indicator_oe = cur.ld_oe;
    assign ref_div_by2 = cur.ref_by2;
    assign fin_khz = cur.fin;
    assign vco_target_mhz = cur.vco;
    assign vco_cal_active = cur.state == srcs_pkg::SRCS_CAL;
    assign vco_fine_active = cur.state == srcs_pkg::SRCS_FINE;
    assign tune_out_of_range = cur.tune_oor;
    assign default_hs_khz = cur.hs_khz;
    assign default_ls_khz = cur.ls_khz;
    assign bus_if_reset = cur.bus_rst;
    assign strap_latched = cur.straps;
    assign high_speed_clock_out = cur.hs_clk;
    assign low_speed_clock_out = cur.ls_clk;
    assign feedback_clock_out = cur.fb_clk;

endmodule
`default_nettype wire

// ===== inc/srcs_pkg.sv
// Package: constants and types for the synthesizer reset/calibration sequencer
package srcs_pkg;

    // Input frequency select strap codes {high, low}
    localparam logic [1:0] FSEL_20M = 2'h0;
    localparam logic [1:0] FSEL_10M = 2'h1;
    localparam logic [1:0] FSEL_12M8 = 2'h2;
    localparam logic [1:0] FSEL_25M = 2'h3;

    // Input frequencies in kHz, indexed by strap code
    localparam logic [15:0] FIN_KHZ_20M = 16'h4E20;
    localparam logic [15:0] FIN_KHZ_10M = 16'h2710;
    localparam logic [15:0] FIN_KHZ_12M8 = 16'h3200;
    localparam logic [15:0] FIN_KHZ_25M = 16'h61A8;

    // Reference pre-divider settings
    localparam logic REF_DIV_BYPASS = 1'b0;
    localparam logic REF_DIV_BY2 = 1'b1;

    // VCO target after reset, in MHz (2.5 GHz)
    localparam logic [11:0] VCO_RESET_MHZ = 12'h9C4;

    // Tuning window around the calibrated point, ppm
    localparam logic [9:0] TUNE_WINDOW_PPM = 10'h1F4;

    // Default output frequencies in kHz per output-mode strap
    localparam logic [19:0] OUT_HS_KHZ_MODE0 = 20'h1E848;
    localparam logic [19:0] OUT_HS_KHZ_MODE1 = 20'h2625A;
    localparam logic [19:0] OUT_LS_KHZ_DEF = 20'h061A8;

    // Default divider ratios (VCO 2.5 GHz): prescaler then per-output dividers
    localparam logic [7:0] PRE_DIV_DEF = 8'h04;
    localparam logic [7:0] HS_DIV_MODE0 = 8'h05;
    localparam logic [7:0] HS_DIV_MODE1 = 8'h04;
    localparam logic [7:0] LS_DIV_DEF = 8'h19;
    localparam logic [7:0] FB_DIV_DEF = 8'h19;

    // Default sequencer step counts (cycles of clk_sys)
    localparam int CAL_CYCLES_DEF = 64;
    localparam int LOCK_CYCLES_DEF = 32;

    // Sequencer states, one-hot
    typedef enum logic [3:0] {
        SRCS_RESET = 4'h1,
        SRCS_CAL = 4'h2,
        SRCS_FINE = 4'h4,
        SRCS_LOCKED = 4'h8
    } srcs_state_t;

endpackage
